/* hw/slt_eval.sv */
// combinational evaluator of trigger functions a and b
`timescale 1ns/1ps
module slt_eval
    import slt_pkg::*;
(
    // link to top
    slt_eval_if.eval ev
);
    logic [3:0] term_a;
    logic [3:0] term_b;

    // one term per channel; an edge term is rising, inverted is falling
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_term
            assign term_a[i] = ev.func_a.use_term[i] &
                (ev.func_a.edge_term[i] ?
                    (ev.func_a.inv_term[i] ? ev.fall[i] : ev.rise[i]) :
                    (ev.lvl[i] ^ ev.func_a.inv_term[i]));
            assign term_b[i] = ev.func_b.use_term[i] &
                (ev.func_b.edge_term[i] ?
                    (ev.func_b.inv_term[i] ? ev.fall[i] : ev.rise[i]) :
                    (ev.lvl[i] ^ ev.func_b.inv_term[i]));
        end
    endgenerate

    // terms are ORed; a cleared function has no term and is never true
    assign ev.hit_a = |term_a;
    assign ev.hit_b = |term_b;
endmodule

/* hw/slt_eval_if.sv */
// carrier between the top and the function evaluator
`timescale 1ns/1ps
interface slt_eval_if;
    import slt_pkg::*;
    logic [3:0] lvl;
    logic [3:0] rise;
    logic [3:0] fall;
    slt_func_t  func_a;
    slt_func_t  func_b;
    logic       hit_a;
    logic       hit_b;
    modport top  (output lvl, rise, fall, func_a, func_b,
                  input hit_a, hit_b);
    modport eval (input lvl, rise, fall, func_a, func_b,
                  output hit_a, hit_b);
endinterface

/* hw/slt_params.svh */
// constants for the sequential logic trigger block
`ifndef SLT_PARAMS_SVH
`define SLT_PARAMS_SVH
`define SLT_NCH        4
`define SLT_SYNC_LEN   3
`define SLT_SYNC_MID   1
`define SLT_SYNC_END   2
`define SLT_INIT_A_LVL 4'h1
`define SLT_INIT_A_EDG 4'h0
`define SLT_INIT_A_INV 4'h0
`define SLT_INIT_A_USE 4'h1
`define SLT_CLEAR_TERM 4'h0
`endif

/* hw/slt_pkg.sv */
// types shared by the sequential logic trigger modules
package slt_pkg;
    // one stored trigger function: per-channel term enables and modifiers
    typedef struct packed {
        logic [3:0] use_term;
        logic [3:0] edge_term;
        logic [3:0] inv_term;
    } slt_func_t;

    typedef enum logic {
        SLT_SEL_A,
        SLT_SEL_B
    } slt_sel_t;
endpackage

/* hw/slt_trigger.sv */
// sequential logic trigger: programmable functions a/b, a-then-b, ext clock
// Operation
// - in sequential mode a true function a only arms, and nothing fires before.
// - once armed, the first following function b issues the trigger.
// - functions a and b are stored apart; selecting one leaves the other intact.
// - selecting a or b in sequential mode changes only the shown function and, with sync off, the view output.
// - the sequential control toggles on each press, its indicator following.
// - a function is the or of channel terms, each optionally inverted.
// - with ext clock sync on, the view output shows the synchronised clock.
// - in ext clock mode the function is sampled on the chosen clock edge.
// - a cleared function never produces a trigger.
// - with sync on and no clock, the view rests low for ecl, high for ttl.
// - sync with no clock present gives no trigger and a steady view.
// - reset selects a alone, modes off, a is channel 1 high, b cleared.
// - an edge term is true on the rising edge, inverted on the falling edge.
`timescale 1ns/1ps
`include "slt_params.svh"
module slt_trigger
    import slt_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // probed circuit
    input  wire logic [3:0] chan_in,
    input  wire logic       ext_clk,
    input  wire logic       ext_clk_ttl,
    // front panel: one-cycle button pulses
    input  wire logic       sel_a_press,
    input  wire logic       sel_b_press,
    input  wire logic       seq_press,
    input  wire logic       clear_press,
    input  wire logic       or_press,
    input  wire logic       not_press,
    input  wire logic       edge_press,
    input  wire logic [3:0] chan_press,
    input  wire logic       sync_press,
    input  wire logic       slope_press,
    // front panel indicators
    output logic            sel_b_shown,
    output logic            seq_on,
    output logic            sync_on,
    output logic            slope_rise,
    output slt_func_t       shown_func,
    output logic            armed,
    // trigger outputs
    output logic            trig_out,
    output logic            trigger_view_output
);
    typedef struct packed {
        logic [`SLT_SYNC_LEN-1:0] chs0, chs1, chs2, chs3;
        logic [`SLT_SYNC_LEN-1:0] clks;
        logic [3:0] lvl_f;  // accepted channel levels
        logic       clk_f;  // accepted ext clock level
        slt_func_t  fa;
        slt_func_t  fb;
        slt_sel_t   sel;
        logic       seq;
        logic       sync;
        logic       rise;
        logic       arm;
        logic       trig;
        logic       view;
        logic       pend_not;
        logic       pend_edge;
    } slt_state_t;

    slt_state_t st;
    slt_state_t next_st;
    slt_eval_if ev ();
    slt_func_t  edit;
    logic [3:0] lvl_mid;
    logic [3:0] lvl_end;
    logic [3:0] lvl_now;
    logic [3:0] lvl_old;
    logic       clk_mid;
    logic       clk_end;
    logic       clk_now;
    logic       clk_old;
    logic       clk_edge;
    logic       eval_en;
    logic       fire_a;
    logic       fire_b;
    logic       fire;

    slt_eval u_eval (
        .ev (ev)
    );

    // stable levels: a change counts once stages two and three agree;
    // a one-cycle glitch leaves the accepted level where it was
    always_comb begin
        lvl_mid = {st.chs3[`SLT_SYNC_MID], st.chs2[`SLT_SYNC_MID],
                   st.chs1[`SLT_SYNC_MID], st.chs0[`SLT_SYNC_MID]};
        lvl_end = {st.chs3[`SLT_SYNC_END], st.chs2[`SLT_SYNC_END],
                   st.chs1[`SLT_SYNC_END], st.chs0[`SLT_SYNC_END]};
        clk_mid = st.clks[`SLT_SYNC_MID];
        clk_end = st.clks[`SLT_SYNC_END];
        lvl_now = (lvl_mid & lvl_end) | (st.lvl_f & (lvl_mid | lvl_end));
        lvl_old = st.lvl_f;
        clk_now = (clk_mid & clk_end) | (st.clk_f & (clk_mid | clk_end));
        clk_old = st.clk_f;
    end

    assign ev.lvl    = lvl_now;
    assign ev.rise   = lvl_now & ~lvl_old;
    assign ev.fall   = ~lvl_now & lvl_old;
    assign ev.func_a = st.fa;
    assign ev.func_b = st.fb;

    // sampling moment: every cycle, or on the chosen ext clock edge
    assign clk_edge = st.rise ? (clk_now & ~clk_old)
                              : (~clk_now & clk_old);
    assign eval_en  = st.sync ? clk_edge : 1'b1;
    assign fire_a   = eval_en & ev.hit_a;
    assign fire_b   = eval_en & ev.hit_b;

    // a alone, b alone, or a arms and next b fires
    always_comb begin
        if (st.seq)
            fire = st.arm & fire_b;
        else if (st.sel == SLT_SEL_B)
            fire = fire_b;
        else
            fire = fire_a;
    end

    // panel edits apply to the selected function only
    always_comb begin
        edit = (st.sel == SLT_SEL_A) ? st.fa : st.fb;
        if (clear_press) begin
            edit.use_term  = `SLT_CLEAR_TERM;
            edit.edge_term = `SLT_CLEAR_TERM;
            edit.inv_term  = `SLT_CLEAR_TERM;
        end
        // not/edge modify the next channel term entered
        for (int k = 0; k < `SLT_NCH; k++) begin
            if (chan_press[k]) begin
                edit.use_term[k]  = 1'b1;
                edit.inv_term[k]  = st.pend_not;
                edit.edge_term[k] = st.pend_edge;
            end
        end
    end

    // next state
    always_comb begin
        next_st = st;
        next_st.chs0 = {st.chs0[`SLT_SYNC_MID:0], chan_in[0]};
        next_st.chs1 = {st.chs1[`SLT_SYNC_MID:0], chan_in[1]};
        next_st.chs2 = {st.chs2[`SLT_SYNC_MID:0], chan_in[2]};
        next_st.chs3 = {st.chs3[`SLT_SYNC_MID:0], chan_in[3]};
        next_st.clks = {st.clks[`SLT_SYNC_MID:0], ext_clk};
        // remember the accepted levels for the next edge compare
        next_st.lvl_f = lvl_now;
        next_st.clk_f = clk_now;
        if (sel_a_press)
            next_st.sel = SLT_SEL_A;
        else if (sel_b_press)
            next_st.sel = SLT_SEL_B;
        if (st.sel == SLT_SEL_A)
            next_st.fa = edit;
        else
            next_st.fb = edit;
        if (not_press)
            next_st.pend_not = ~st.pend_not;
        if (edge_press)
            next_st.pend_edge = ~st.pend_edge;
        if (|chan_press || clear_press || or_press) begin
            next_st.pend_not  = 1'b0;
            next_st.pend_edge = 1'b0;
        end
        if (seq_press)
            next_st.seq = ~st.seq;
        if (sync_press)
            next_st.sync = ~st.sync;
        if (slope_press)
            next_st.rise = ~st.rise;
        // arming: a arms, a fire disarms, leaving the mode drops it
        if (!st.seq || seq_press)
            next_st.arm = 1'b0;
        else if (fire)
            next_st.arm = 1'b0;
        else if (fire_a)
            next_st.arm = 1'b1;
        next_st.trig = fire;
        // view shows clock in sync mode; idle clock rests at the jumper level
        // on entry the view takes the strap level; the strap is a static
        // board setting, so it needs no synchroniser
        if (st.sync)
            next_st.view = clk_now;
        else if (sync_press)
            next_st.view = ext_clk_ttl;
        else
            next_st.view = st.sel == SLT_SEL_B ? ev.hit_b : ev.hit_a;
    end

    // register the whole state; reset loads the power-up panel setup
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            st <= '0;
            st.fa.use_term  <= `SLT_INIT_A_USE;
            st.fa.edge_term <= `SLT_INIT_A_EDG;
            st.fa.inv_term  <= `SLT_INIT_A_INV;
            st.sel          <= SLT_SEL_A;
            st.rise         <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign sel_b_shown         = (st.sel == SLT_SEL_B);
    assign seq_on              = st.seq;
    assign sync_on             = st.sync;
    assign slope_rise          = st.rise;
    assign shown_func          = (st.sel == SLT_SEL_A) ? st.fa : st.fb;
    assign armed               = st.arm;
    assign trig_out            = st.trig;
    assign trigger_view_output = st.view;
endmodule

/* verif/slt_checker.sv */
// port assertions for the sequential logic trigger
`timescale 1ns/1ps
module slt_chk
    import slt_pkg::*;
(
    // clock, reset and stimulus
    input wire logic      clk_sys,
    input wire logic      rstn,
    input wire logic      ext_clk,
    input wire logic      ext_clk_ttl,
    input wire logic      sel_a_press,
    input wire logic      sel_b_press,
    input wire logic      seq_press,
    // indicators and trigger
    input wire logic      seq_on,
    input wire logic      sync_on,
    input wire logic      armed,
    input wire slt_func_t shown_func,
    input wire logic      trig_out,
    input wire logic      trigger_view_output
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // six cycles lets the three-flop synchroniser drain
    sequence s_quiet;
        (sync_on && $stable(ext_clk)) [*6];
    endsequence
    sequence s_cleared;
        (!seq_on && shown_func == 12'h000) [*3];
    endsequence
    a_no_early: assert property ($past(seq_on) && trig_out
        |-> $past(armed)) else $error("early fire");
    a_fire_disarms: assert property ($past(seq_on) && trig_out
        |-> !armed) else $error("still armed");
    a_sel_keeps: assert property ((sel_a_press || sel_b_press)
        && !seq_press |=> $stable(seq_on)) else $error("seq lost");
    a_seq_toggle: assert property (seq_press
        |=> seq_on != $past(seq_on)) else $error("no toggle");
    a_cleared_quiet: assert property (s_cleared |-> !trig_out)
        else $error("cleared fired");
    a_sync_entry: assert property ($rose(sync_on)
        |-> ##[0:1] trigger_view_output == ext_clk_ttl)
        else $error("view level");
    a_no_clock: assert property (s_quiet |=> !trig_out)
        else $error("fired idle");
    a_reset_state: assert property ($rose(rstn)
        |-> shown_func == 12'h100 && !seq_on && !sync_on && !armed)
        else $error("reset state");
endmodule
bind slt_trigger slt_chk u_chk (.clk_sys, .rstn, .ext_clk, .ext_clk_ttl,
    .sel_a_press, .sel_b_press, .seq_press, .seq_on, .sync_on, .armed,
    .shown_func, .trig_out, .trigger_view_output);

/* verif/slt_circuit.sv */
// model of the probed circuit: channel levels and external clock
`timescale 1ns/1ps
module slt_circuit (
    // lines into the trigger unit
    output logic [3:0] chan,
    output logic       xclk
);
    // clock idles at the ttl strap level, so the view stays put
    initial {xclk, chan} = 5'h10;
    task automatic set(input logic [4:0] v);
        {xclk, chan} = v;
    endtask
    // clock runs only inside a burst, 400 ns a period
    task automatic burst(input int n);
        repeat (n) begin
            #200 xclk = 1'b0;
            #200 xclk = 1'b1;
        end
    endtask
endmodule

/* verif/tb.sv */
// self-checking bench for the sequential logic trigger
`timescale 1ns/1ps
module tb;
    import slt_pkg::*;
    logic       clk_sys, rstn, xc, tt, sb, sq, sy, sr, ar, tr, vw;
    logic [8:0] b;
    logic [3:0] cp, ch;
    slt_func_t  sf;
    int         error_cnt, checked;
    slt_circuit cm (.chan(ch), .xclk(xc));
    // b from bit 0: sel_a sel_b seq clear or not edge sync slope
    slt_trigger uut (.clk_sys, .rstn, .chan_in(ch), .ext_clk(xc),
        .ext_clk_ttl(tt), .sel_a_press(b[0]), .sel_b_press(b[1]),
        .seq_press(b[2]), .clear_press(b[3]), .or_press(b[4]),
        .not_press(b[5]), .edge_press(b[6]), .chan_press(cp),
        .sync_press(b[7]), .slope_press(b[8]), .sel_b_shown(sb),
        .seq_on(sq), .sync_on(sy), .slope_rise(sr), .shown_func(sf),
        .armed(ar), .trig_out(tr), .trigger_view_output(vw));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [11:0] s, e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("Error at %0t: %h vs %h", $time, s, e);
        end
    endtask
    // inputs move 2 ns after the edge, clear of the sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic pr(input logic [8:0] v, input logic [3:0] c);
        b = v;
        cp = c;
        cyc(1);
        b = 9'h0;
        cp = 4'h0;
        cyc(1);
    endtask
    // clear, modifiers one by one, then channel keys
    task automatic prog(input logic [8:0] m, input logic [3:0] c);
        pr(9'h008, 4'h0);
        for (int i = 0; i < 9; i++)
            if (m[i]) pr(9'h001 << i, 4'h0);
        pr(9'h000, c);
    endtask
    // set {clock, channels}, settle, count fires; ff means at least one
    task automatic ev(input logic [4:0] c, input int s, n,
                      input logic [7:0] e);
        logic [7:0] k;
        k = 8'h0;
        cm.set(c);
        cyc(s);
        repeat (n) begin
            cyc(1);
            k += {7'h0, tr !== 1'b0};
        end
        chk(12'((&e && |k) ? e : k), 12'(e));
    endtask
    // reset state, stored functions, or/not terms, edges
    task automatic t_func;
        chk(12'({sb, sq, sy, sr, ar, tr, vw}), 12'h000);
        chk(sf, 12'h100);
        ev(5'h11, 0, 8, 8'hff);
        pr(9'h002, 4'h0);
        chk(sf, 12'h000);
        prog(9'h020, 4'h1);
        chk(sf, 12'h101);
        ev(5'h11, 6, 8, 8'h0);
        ev(5'h10, 0, 8, 8'hff);
        pr(9'h001, 4'h0);
        chk(sf, 12'h100);
        pr(9'h002, 4'h0);
        prog(9'h000, 4'h1);
        pr(9'h010, 4'h0);
        pr(9'h020, 4'h0);
        pr(9'h000, 4'h2);
        chk(sf, 12'h302);
        ev(5'h12, 6, 8, 8'h0);
        ev(5'h13, 6, 8, 8'hff);
        prog(9'h040, 4'h1);
        ev(5'h10, 6, 8, 8'h0);
        ev(5'h11, 0, 12, 8'h1);
        prog(9'h060, 4'h1);
        ev(5'h10, 0, 12, 8'h1);
    endtask
    // a arms, the next b fires once, then a fresh a is needed
    task automatic t_seq;
        prog(9'h000, 4'h2);
        cm.set(5'h10);
        pr(9'h004, 4'h0);
        chk(12'(sq), 12'h001);
        ev(5'h12, 0, 12, 8'h0);
        pr(9'h001, 4'h0);
        chk(12'({sq, sb}), 12'h002);
        ev(5'h11, 0, 8, 8'h0);
        chk(12'(ar), 12'h001);
        ev(5'h12, 0, 16, 8'h1);
        chk(12'(ar), 12'h000);
        pr(9'h004, 4'h0);
        chk(12'(sq), 12'h000);
    endtask
    // external clock: view, slope choice, cleared function
    task automatic t_sync;
        cm.set(5'h11);
        pr(9'h080, 4'h0);
        chk(12'({sy, vw}), 12'h003);
        ev(5'h11, 0, 12, 8'h0);
        chk(12'(vw), 12'h001);
        fork
            cm.burst(3);
            ev(5'h11, 0, 30, 8'h3);
            begin
                cyc(10);
                chk(12'(vw), 12'h000);
                cyc(3);
                chk(12'(vw), 12'h001);
            end
        join
        ev(5'h01, 0, 10, 8'h1);
        ev(5'h11, 0, 10, 8'h0);
        pr(9'h100, 4'h0);
        chk(12'(sr), 12'h001);
        ev(5'h01, 0, 10, 8'h0);
        ev(5'h11, 0, 10, 8'h1);
        pr(9'h008, 4'h0);
        fork
            cm.burst(3);
            ev(5'h11, 0, 30, 8'h0);
        join
        // ecl strap with its clock idling low: sync off, then on again
        tt = 1'b0;
        cm.set(5'h00);
        pr(9'h080, 4'h0);
        pr(9'h080, 4'h0);
        chk(12'({sy, vw}), 12'h002);
    endtask
    task automatic finish_test;
        $display("checked %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        b = 9'h0;
        cp = 4'h0;
        tt = 1'b1;
        error_cnt = 0;
        checked = 0;
        cyc(12);
        rstn = 1'b1;
        t_func;
        t_seq;
        t_sync;
        finish_test;
    end
endmodule
